// [core/mpt_timer.sv]
// Top of the match based pwm timer: register port, counter, matches, outputs.
// Assumes one 200 MHz clock; the sync pair joins two instances on that clock.
// What this block does
// - A 32-bit counter advances through a 32-bit prescaler, clocked by mclk_i or capture edges.
// - Seven match comparators serve up to six single-edge or three double-edge outputs or a mix.
// - Comparator 0 is the cycle match, and on it the counter restarts a shared period.
// - Single-edge outputs go high at each cycle match unless their setting keeps them low.
// - A single-edge output falls when the counter meets its own comparator.
// - A double-edge output rises on one comparator and falls on another, anywhere in the period.
// - Rise before fall gives a high pulse, fall before rise gives a low pulse.
// - Each match may flag an interrupt and may keep counting, stop or reset the counter.
// - While modulating, new match values take effect only when software releases them, at the period start.
// - With modulation off the block is a plain timer and drives no modulated output.
// - Period and width are any whole tick counts, and all outputs share one rate.
// - Two instances start one clock apart: the primary's enable also starts the secondary.
`timescale 1ns/10ps
`default_nettype none
module mpt_timer
	import mpt_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Register port
	input wire mpt_bus_req_s bus_i,
	output logic [MPT_DW-1:0] rdata_o,
	// Capture pins
	input wire logic [MPT_NUM_CAP-1:0] cap_i,
	// Lockstep pair
	input wire logic sync_start_i,
	output logic sync_start_o,
	// Outputs
	output logic [MPT_NUM_OUT-1:0] pwm_o,
	output logic match_irq_o
);

	// ********************************
	// Registers
	// ********************************
	logic [MPT_CTRL_W-1:0] ctrl_q;
	logic [31:0] count_q;
	logic [31:0] pre_limit_q;
	logic [MPT_MC_W-1:0] mc_q;
	logic [MPT_NUM_MATCH-1:0] flag_q;
	logic [MPT_CC_W-1:0] cc_q;
	logic [MPT_OC_W-1:0] oc_q;
	logic [MPT_NUM_MATCH-1:0] release_q;
	logic [31:0] shadow_q [MPT_NUM_MATCH];
	logic [31:0] active_q [MPT_NUM_MATCH];
	logic [MPT_NUM_OUT-1:0] pwm_q;
	logic irq_q;
	logic sync_q;
	logic [MPT_DW-1:0] rdata_q;

	// ********************************
	// Decode and match events
	// ********************************
	logic tick;
	logic [31:0] pre_count;
	mpt_cnt_cfg_s cnt_cfg;
	logic pwm_mode;
	logic wr_ctrl;
	logic wr_count;
	logic wr_flag;
	logic wr_release;
	logic [MPT_NUM_MATCH-1:0] wr_match;
	logic [MPT_NUM_MATCH-1:0] hit;
	logic [MPT_NUM_MATCH-1:0] hit_int;
	logic [MPT_NUM_MATCH-1:0] hit_rst;
	logic [MPT_NUM_MATCH-1:0] hit_stop;
	logic period_start;

	assign pwm_mode = ctrl_q[MPT_CTRL_PWM];
	assign wr_ctrl = bus_i.we && bus_i.addr == MPT_OFF_CTRL;
	assign wr_count = bus_i.we && bus_i.addr == MPT_OFF_COUNT;
	assign wr_flag = bus_i.we && bus_i.addr == MPT_OFF_MATCH_FLAG;
	assign wr_release = bus_i.we && bus_i.addr == MPT_OFF_RELEASE;

	always_comb begin
		cnt_cfg.en = ctrl_q[MPT_CTRL_EN];
		cnt_cfg.clr = ctrl_q[MPT_CTRL_RST];
		cnt_cfg.mode = mpt_src_e'(cc_q[MPT_CC_MODE_LSB +: 2]);
		cnt_cfg.sel = cc_q[MPT_CC_SEL_LSB +: 2];
		cnt_cfg.limit = pre_limit_q;
	end

	genvar gi;
	generate
		for (gi = 0; gi < MPT_NUM_MATCH; gi++) begin : g_match
			localparam logic [7:0] OFF = MPT_OFF_MATCH0 + 8'(gi) * MPT_OFF_MATCH_STEP;
			assign wr_match[gi] = bus_i.we && bus_i.addr == OFF;
			assign hit[gi] = tick && count_q == active_q[gi];
			assign hit_int[gi] = hit[gi] & mc_q[gi*MPT_MC_STRIDE + MPT_MC_INT];
			assign hit_stop[gi] = hit[gi] & mc_q[gi*MPT_MC_STRIDE + MPT_MC_STOP];
			if (gi == 0) begin : g_cycle
				// Cycle match always restarts the period while modulating
				assign hit_rst[gi] = hit[gi] & (mc_q[MPT_MC_RST] | pwm_mode);
			end else begin : g_plain
				assign hit_rst[gi] = hit[gi] & mc_q[gi*MPT_MC_STRIDE + MPT_MC_RST];
			end

			// Shadow is what software sees; active is what the comparator uses
			always_ff @(posedge mclk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					shadow_q[gi] <= MPT_RST_WORD;
				end else if (wr_match[gi]) begin
					shadow_q[gi] <= bus_i.wdata;
				end
			end

			always_ff @(posedge mclk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					active_q[gi] <= MPT_RST_WORD;
				end else if (!pwm_mode) begin
					active_q[gi] <= shadow_q[gi];
				end else if (period_start && release_q[gi]) begin
					active_q[gi] <= shadow_q[gi];
				end
			end
		end
	endgenerate

	assign period_start = hit[0] & pwm_mode;

	// ********************************
	// Tick source and prescaler
	// ********************************
	mpt_tick_gen u_tick (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.cfg_i(cnt_cfg),
		.cap_i(cap_i),
		.tick_o(tick),
		.pre_count_o(pre_count)
	);

	// ********************************
	// Control and lockstep start
	// ********************************
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_q <= MPT_RST_CTRL;
		end else if (wr_ctrl) begin
			ctrl_q <= bus_i.wdata[MPT_CTRL_W-1:0];
		end else if (|hit_stop) begin
			ctrl_q[MPT_CTRL_EN] <= 1'b0;
		end else if (ctrl_q[MPT_CTRL_FOLLOW] && sync_start_i) begin
			// Secondary waits for the primary's enable pulse
			ctrl_q[MPT_CTRL_EN] <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync_q <= 1'b0;
		end else begin
			// Secondary sees this one cycle late, so it lags by one clock
			sync_q <= wr_ctrl & bus_i.wdata[MPT_CTRL_EN] & bus_i.wdata[MPT_CTRL_LEAD];
		end
	end

	// ********************************
	// Main counter
	// ********************************
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			count_q <= MPT_RST_WORD;
		end else if (ctrl_q[MPT_CTRL_RST]) begin
			count_q <= MPT_RST_WORD;
		end else if (wr_count) begin
			count_q <= bus_i.wdata;
		end else if (tick) begin
			if (|hit_rst) begin
				count_q <= MPT_RST_WORD;
			end else begin
				count_q <= count_q + 32'h0000_0001;
			end
		end
	end

	// ********************************
	// Plain configuration registers
	// ********************************
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pre_limit_q <= MPT_RST_WORD;
			mc_q <= MPT_RST_MC;
			cc_q <= MPT_RST_CC;
			oc_q <= MPT_RST_OC;
		end else if (bus_i.we) begin
			case (bus_i.addr)
				MPT_OFF_PRE_LIMIT: pre_limit_q <= bus_i.wdata;
				MPT_OFF_MATCH_CTRL: mc_q <= bus_i.wdata[MPT_MC_W-1:0];
				MPT_OFF_CNT_CTRL: cc_q <= bus_i.wdata[MPT_CC_W-1:0];
				MPT_OFF_OUT_CTRL: oc_q <= bus_i.wdata[MPT_OC_W-1:0];
				default: ;
			endcase
		end
	end

	// ********************************
	// Release bits and match flags
	// ********************************
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			release_q <= MPT_RST_MVEC;
		end else if (wr_release) begin
			// A fresh release must not be lost to a same-cycle period start
			release_q <= bus_i.wdata[MPT_NUM_MATCH-1:0];
		end else if (period_start) begin
			release_q <= MPT_RST_MVEC;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flag_q <= MPT_RST_MVEC;
		end else begin
			// Set beats a write-one clear in the same cycle
			flag_q <= (flag_q & ~({MPT_NUM_MATCH{wr_flag}} & bus_i.wdata[MPT_NUM_MATCH-1:0]))
				| hit_int;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(flag_q | hit_int);
		end
	end

	// ********************************
	// Modulated outputs
	// ********************************
	genvar go;
	generate
		for (go = 1; go <= MPT_NUM_OUT; go++) begin : g_out
			logic dbl;
			logic set_ev;
			logic clr_ev;
			if (go == 1) begin : g_single_only
				assign dbl = 1'b0;
			end else begin : g_selectable
				assign dbl = oc_q[MPT_OC_DBL_LSB + go];
			end
			// Single edge: rise on the cycle match, fall on own match
			assign set_ev = dbl ? hit[go-1] : hit[0];
			assign clr_ev = hit[go];

			always_ff @(posedge mclk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					pwm_q[go-1] <= 1'b0;
				end else if (!pwm_mode || !oc_q[MPT_OC_OE_LSB + go - 1]) begin
					pwm_q[go-1] <= 1'b0;
				end else if (clr_ev) begin
					// Fall wins a tie, so a match equal to the period keeps it low
					pwm_q[go-1] <= 1'b0;
				end else if (set_ev) begin
					pwm_q[go-1] <= 1'b1;
				end
			end
		end
	endgenerate

	// ********************************
	// Read port
	// ********************************
	logic [MPT_DW-1:0] rd_mux;
	always_comb begin
		rd_mux = MPT_RST_WORD;
		case (bus_i.addr)
			MPT_OFF_CTRL: rd_mux = 32'(ctrl_q);
			MPT_OFF_COUNT: rd_mux = count_q;
			MPT_OFF_PRE_LIMIT: rd_mux = pre_limit_q;
			MPT_OFF_PRE_COUNT: rd_mux = pre_count;
			MPT_OFF_MATCH_CTRL: rd_mux = 32'(mc_q);
			MPT_OFF_MATCH_FLAG: rd_mux = 32'(flag_q);
			MPT_OFF_CNT_CTRL: rd_mux = 32'(cc_q);
			MPT_OFF_OUT_CTRL: rd_mux = 32'(oc_q);
			MPT_OFF_RELEASE: rd_mux = 32'(release_q);
			default: begin
				for (int k = 0; k < MPT_NUM_MATCH; k++) begin
					if (wr_match_addr(bus_i.addr, k)) begin
						rd_mux = shadow_q[k];
					end
				end
			end
		endcase
	end

	function automatic logic wr_match_addr(input logic [7:0] a, input int k);
		logic [7:0] off;
		off = MPT_OFF_MATCH0 + 8'(k) * MPT_OFF_MATCH_STEP;
		return a == off;
	endfunction

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_q <= MPT_RST_WORD;
		end else if (bus_i.re) begin
			rdata_q <= rd_mux;
		end else begin
			rdata_q <= MPT_RST_WORD;
		end
	end

	assign rdata_o = rdata_q;
	assign pwm_o = pwm_q;
	assign match_irq_o = irq_q;
	assign sync_start_o = sync_q;

endmodule
`default_nettype wire

// [core/mpt_pkg.sv]
// Constants, register map and carrier types of the match based pwm timer.
// Assumes a single 200 MHz clock domain and a plain one-cycle register port.
package mpt_pkg;

	// ********************************
	// Sizes
	// ********************************
	localparam int unsigned MPT_NUM_MATCH = 7;
	localparam int unsigned MPT_NUM_OUT = 6;
	localparam int unsigned MPT_NUM_CAP = 4;
	localparam int unsigned MPT_AW = 8;
	localparam int unsigned MPT_DW = 32;

	// ********************************
	// Register byte offsets
	// ********************************
	localparam logic [7:0] MPT_OFF_CTRL = 8'h00;
	localparam logic [7:0] MPT_OFF_COUNT = 8'h04;
	localparam logic [7:0] MPT_OFF_PRE_LIMIT = 8'h08;
	localparam logic [7:0] MPT_OFF_PRE_COUNT = 8'h0c;
	localparam logic [7:0] MPT_OFF_MATCH_CTRL = 8'h10;
	localparam logic [7:0] MPT_OFF_MATCH_FLAG = 8'h14;
	localparam logic [7:0] MPT_OFF_CNT_CTRL = 8'h18;
	localparam logic [7:0] MPT_OFF_OUT_CTRL = 8'h1c;
	localparam logic [7:0] MPT_OFF_RELEASE = 8'h20;
	localparam logic [7:0] MPT_OFF_MATCH0 = 8'h24;
	localparam logic [7:0] MPT_OFF_MATCH_STEP = 8'h04;

	// ********************************
	// Field positions
	// ********************************
	localparam int unsigned MPT_CTRL_EN = 0;
	localparam int unsigned MPT_CTRL_RST = 1;
	localparam int unsigned MPT_CTRL_PWM = 3;
	localparam int unsigned MPT_CTRL_LEAD = 4;
	localparam int unsigned MPT_CTRL_FOLLOW = 5;
	localparam int unsigned MPT_CTRL_W = 6;
	localparam int unsigned MPT_MC_INT = 0;
	localparam int unsigned MPT_MC_RST = 1;
	localparam int unsigned MPT_MC_STOP = 2;
	localparam int unsigned MPT_MC_STRIDE = 3;
	localparam int unsigned MPT_MC_W = 21;
	localparam int unsigned MPT_CC_MODE_LSB = 0;
	localparam int unsigned MPT_CC_SEL_LSB = 2;
	localparam int unsigned MPT_CC_W = 4;
	localparam int unsigned MPT_OC_DBL_LSB = 0;
	localparam int unsigned MPT_OC_OE_LSB = 9;
	localparam int unsigned MPT_OC_W = 15;

	// ********************************
	// Reset values
	// ********************************
	localparam logic [MPT_CTRL_W-1:0] MPT_RST_CTRL = 6'h00;
	localparam logic [31:0] MPT_RST_WORD = 32'h0000_0000;
	localparam logic [MPT_MC_W-1:0] MPT_RST_MC = 21'h00_0000;
	localparam logic [MPT_CC_W-1:0] MPT_RST_CC = 4'h0;
	localparam logic [MPT_OC_W-1:0] MPT_RST_OC = 15'h0000;
	localparam logic [MPT_NUM_MATCH-1:0] MPT_RST_MVEC = 7'h00;

	// ********************************
	// Types
	// ********************************
	typedef enum logic [1:0] {
		MPT_SRC_CLOCK = 2'h0,
		MPT_SRC_RISE = 2'h1,
		MPT_SRC_FALL = 2'h2,
		MPT_SRC_BOTH = 2'h3
	} mpt_src_e;

	typedef struct packed {
		logic [MPT_AW-1:0] addr;
		logic [MPT_DW-1:0] wdata;
		logic we;
		logic re;
	} mpt_bus_req_s;

	typedef struct packed {
		logic en;
		logic clr;
		mpt_src_e mode;
		logic [1:0] sel;
		logic [31:0] limit;
	} mpt_cnt_cfg_s;

endpackage

// [core/mpt_tick_gen.sv]
// Tick source and prescaler of the match based pwm timer.
// Capture pins are asynchronous; everything else is on mclk_i.
`timescale 1ns/10ps
`default_nettype none
module mpt_tick_gen
	import mpt_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Configuration
	input wire mpt_cnt_cfg_s cfg_i,
	// Capture pins
	input wire logic [MPT_NUM_CAP-1:0] cap_i,
	// Counter advance
	output logic tick_o,
	output logic [31:0] pre_count_o
);

	// ********************************
	// Capture input synchroniser
	// ********************************
	logic [MPT_NUM_CAP-1:0] cap_meta_q;
	logic [MPT_NUM_CAP-1:0] cap_sync_q;
	logic [MPT_NUM_CAP-1:0] cap_last_q;
	logic [31:0] pre_q;
	logic cur;
	logic prev;
	logic src_tick;
	logic wrap;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cap_meta_q <= '0;
			cap_sync_q <= '0;
			cap_last_q <= '0;
		end else begin
			cap_meta_q <= cap_i;
			cap_sync_q <= cap_meta_q;
			cap_last_q <= cap_sync_q;
		end
	end

	// ********************************
	// Source select
	// ********************************
	always_comb begin
		cur = cap_sync_q[cfg_i.sel];
		prev = cap_last_q[cfg_i.sel];
		case (cfg_i.mode)
			MPT_SRC_CLOCK: src_tick = 1'b1;
			MPT_SRC_RISE: src_tick = cur & ~prev;
			MPT_SRC_FALL: src_tick = ~cur & prev;
			MPT_SRC_BOTH: src_tick = cur ^ prev;
			default: src_tick = 1'b0;
		endcase
	end

	// ********************************
	// Prescaler
	// ********************************
	assign wrap = (pre_q == cfg_i.limit);
	assign tick_o = cfg_i.en & ~cfg_i.clr & src_tick & wrap;
	assign pre_count_o = pre_q;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pre_q <= MPT_RST_WORD;
		end else if (cfg_i.clr) begin
			pre_q <= MPT_RST_WORD;
		end else if (cfg_i.en && src_tick) begin
			// Limit of zero advances the counter on every source tick
			pre_q <= wrap ? MPT_RST_WORD : pre_q + 32'h0000_0001;
		end
	end

endmodule
`default_nettype wire

// [tb/mpt_timer_asserts.sv]
// Checker for mpt_timer: register port, lockstep pulse, output gating.
// Assumes it is bound to mpt_timer and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module mpt_timer_chk
	import mpt_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Register port
	input wire mpt_bus_req_s bus_i,
	input wire logic [MPT_DW-1:0] rdata_o,
	// Outputs
	input wire logic sync_start_o,
	input wire logic [MPT_NUM_OUT-1:0] pwm_o,
	input wire logic match_irq_o
);
	// ****
	// Shadows of the mode bits
	// ****
	logic pwm_q;
	logic [MPT_NUM_OUT-1:0] oe_q;
	logic ctrl_wr;
	logic lead_wr;
	logic flag_wr;
	assign ctrl_wr = bus_i.we && bus_i.addr == MPT_OFF_CTRL;
	assign lead_wr = ctrl_wr && bus_i.wdata[MPT_CTRL_EN] && bus_i.wdata[MPT_CTRL_LEAD];
	assign flag_wr = bus_i.we && bus_i.addr == MPT_OFF_MATCH_FLAG;
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			pwm_q <= 1'b0;
		else if (ctrl_wr)
			pwm_q <= bus_i.wdata[MPT_CTRL_PWM];
	end
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			oe_q <= '0;
		else if (bus_i.we && bus_i.addr == MPT_OFF_OUT_CTRL)
			oe_q <= bus_i.wdata[MPT_OC_OE_LSB +: MPT_NUM_OUT];
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	// ****
	// Properties
	// ****
	rd_idle_a: assert property (!$past(bus_i.re) |-> rdata_o == '0)
		else $error("read data not zero outside a read");
	unmapped_rd_a: assert property (bus_i.re && bus_i.addr > 8'h3c |=> rdata_o == '0)
		else $error("unmapped read not zero");
	ctrl_upper_a: assert property (bus_i.re && bus_i.addr == MPT_OFF_CTRL
		|=> rdata_o[MPT_DW-1:MPT_CTRL_W] == '0)
		else $error("control upper bits not zero");
	sync_pulse_a: assert property (sync_start_o |=> !sync_start_o)
		else $error("start pulse longer than one cycle");
	sync_cause_a: assert property (sync_start_o |-> $past(lead_wr))
		else $error("start pulse without primary enable");
	pwm_off_a: assert property (!pwm_q && !$past(pwm_q) |-> pwm_o == '0)
		else $error("output driven in timer mode");
	oe_gate_a: assert property ((pwm_o & ~oe_q & ~$past(oe_q)) == '0)
		else $error("disabled output driven");
	// Request line rises with the flags but falls one cycle after them, so it may drop the cycle after a clear
	irq_hold_a: assert property (match_irq_o && !flag_wr && !$past(flag_wr) |=> match_irq_o)
		else $error("match flag dropped without clear");
endmodule
bind mpt_timer mpt_timer_chk chk_u (
	.mclk_i(mclk_i),
	.rstn_i(rstn_i),
	.bus_i(bus_i),
	.rdata_o(rdata_o),
	.sync_start_o(sync_start_o),
	.pwm_o(pwm_o),
	.match_irq_o(match_irq_o)
);
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for mpt_timer.
// Assumes the checker is bound in; one 200 MHz clock drives everything.
`timescale 1ns/10ps
`default_nettype none
module tb
	import mpt_pkg::*;
;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] w;
		logic [31:0] e;
	} mpt_row_s;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	mpt_bus_req_s bus_i = '0;
	logic [31:0] rdata_o;
	logic [3:0] cap_i = 4'h0;
	logic sync_i = 1'b0;
	logic sync_o;
	logic [5:0] pwm_o;
	logic irq;
	int num_errors = 0;
	int n_tests = 0;
	logic [31:0] d;
	mpt_row_s rows [9] = '{
		'{MPT_OFF_PRE_LIMIT, 32'hffff_ffff, 32'hffff_ffff},
		'{MPT_OFF_MATCH_CTRL, 32'hffff_ffff, 32'h001f_ffff},
		'{MPT_OFF_CNT_CTRL, 32'hffff_ffff, 32'h0000_000f},
		'{MPT_OFF_OUT_CTRL, 32'h0000_7e7c, 32'h0000_7e7c},
		'{8'h3c, 32'h1234_5678, 32'h1234_5678},
		'{MPT_OFF_COUNT, 32'h0000_00aa, 32'h0000_00aa},
		'{MPT_OFF_PRE_COUNT, 32'hffff_ffff, 32'h0000_0000},
		'{MPT_OFF_MATCH_FLAG, 32'hffff_ffff, 32'h0000_0000},
		'{8'h80, 32'hffff_ffff, 32'h0000_0000}
	};
	mpt_timer dut_u (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.bus_i(bus_i),
		.rdata_o(rdata_o),
		.cap_i(cap_i),
		.sync_start_i(sync_i),
		.sync_start_o(sync_o),
		.pwm_o(pwm_o),
		.match_irq_o(irq)
	);
	initial forever #2.5 mclk_i = ~mclk_i;
	// ****
	// Bus and check tasks
	// ****
	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		@(posedge mclk_i);
		bus_i.addr <= a;
		bus_i.wdata <= w;
		bus_i.we <= 1'b1;
		@(posedge mclk_i);
		bus_i.we <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk_i);
		bus_i.addr <= a;
		bus_i.re <= 1'b1;
		@(posedge mclk_i);
		bus_i.re <= 1'b0;
		#1;
		chk(rdata_o, e);
	endtask
	// Rising edges in the upper half, high cycles in the lower, over 100 cycles
	task automatic meas(input int k, input logic [31:0] e);
		logic p;
		logic [31:0] r;
		r = '0;
		@(posedge mclk_i);
		#1;
		p = pwm_o[k];
		repeat (100) begin
			@(posedge mclk_i);
			#1;
			r[15:0] += 16'(pwm_o[k]);
			r[31:16] += 16'(pwm_o[k] && !p);
			p = pwm_o[k];
		end
		chk(r, e);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Whole run is about a thousand cycles
	initial begin
		#100000;
		num_errors++;
		conclude();
	end
	// ****
	// Tests
	// ****
	initial begin
		repeat (3) @(posedge mclk_i);
		rstn_i <= 1'b1;
		foreach (rows[i]) begin
			rdc(rows[i].a, '0);
			wr(rows[i].a, rows[i].w);
			rdc(rows[i].a, rows[i].e);
			wr(rows[i].a, '0);
		end
		$display("register table done");
		wr(MPT_OFF_MATCH0, 32'd9);
		wr(8'h28, 32'd4);
		wr(8'h2c, 32'd7);
		wr(MPT_OFF_OUT_CTRL, 32'h0000_0604);
		wr(MPT_OFF_RELEASE, 32'h0000_0007);
		wr(MPT_OFF_CTRL, 32'h0000_0009);
		repeat (30) @(posedge mclk_i);
		meas(0, 32'h000a_0032);
		meas(1, 32'h000a_001e);
		// New values must wait for the release
		wr(8'h28, 32'd7);
		wr(8'h2c, 32'd4);
		meas(0, 32'h000a_0032);
		wr(MPT_OFF_RELEASE, 32'h0000_0006);
		repeat (30) @(posedge mclk_i);
		meas(0, 32'h000a_0050);
		meas(1, 32'h000a_0046);
		wr(MPT_OFF_PRE_LIMIT, 32'd1);
		repeat (40) @(posedge mclk_i);
		meas(0, 32'h0005_0050);
		$display("pwm outputs done");
		wr(MPT_OFF_CTRL, 32'h0000_0000);
		wr(MPT_OFF_PRE_LIMIT, 32'd0);
		wr(MPT_OFF_CTRL, 32'h0000_0002);
		wr(MPT_OFF_MATCH_CTRL, 32'h0000_0a00);
		wr(8'h30, 32'd5);
		wr(MPT_OFF_CTRL, 32'h0000_0001);
		repeat (20) @(posedge mclk_i);
		rdc(MPT_OFF_CTRL, 32'h0);
		rdc(MPT_OFF_COUNT, 32'd6);
		chk(32'(irq), 32'h1);
		rdc(MPT_OFF_MATCH_FLAG, 32'h8);
		wr(MPT_OFF_MATCH_FLAG, 32'h8);
		rdc(MPT_OFF_MATCH_FLAG, 32'h0);
		chk(32'(irq), 32'h0);
		$display("match stop done");
		wr(MPT_OFF_CTRL, 32'h0000_0002);
		wr(MPT_OFF_MATCH_CTRL, 32'h0000_0400);
		wr(MPT_OFF_CTRL, 32'h0000_0001);
		repeat (20) @(posedge mclk_i);
		// Match 3 at count 5 wraps the count, six counts a lap
		rdc(MPT_OFF_COUNT, 32'd3);
		$display("match reset done");
		wr(MPT_OFF_MATCH_CTRL, 32'h0);
		for (int m = 1; m < 4; m++) begin
			wr(MPT_OFF_CTRL, 32'h0000_0002);
			wr(MPT_OFF_CNT_CTRL, 32'(m) | 32'h8);
			wr(MPT_OFF_CTRL, 32'h0000_0001);
			repeat (4) begin
				@(posedge mclk_i);
				cap_i[2] <= 1'b1;
				repeat (4) @(posedge mclk_i);
				cap_i[2] <= 1'b0;
				repeat (4) @(posedge mclk_i);
			end
			repeat (6) @(posedge mclk_i);
			rdc(MPT_OFF_COUNT, (m == 3) ? 32'd8 : 32'd4);
		end
		wr(MPT_OFF_CNT_CTRL, 32'h0);
		$display("capture counting done");
		wr(MPT_OFF_CTRL, 32'h0000_0011);
		#1;
		chk(32'(sync_o), 32'h1);
		wr(MPT_OFF_CTRL, 32'h0000_0020);
		@(posedge mclk_i);
		sync_i <= 1'b1;
		@(posedge mclk_i);
		sync_i <= 1'b0;
		rdc(MPT_OFF_CTRL, 32'h0000_0021);
		$display("lockstep done");
		wr(MPT_OFF_CTRL, 32'h0000_0009);
		repeat (15) @(posedge mclk_i);
		rstn_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		#1;
		chk(32'({pwm_o, irq, sync_o}), 32'h0);
		rstn_i <= 1'b1;
		rdc(MPT_OFF_CTRL, 32'h0);
		rdc(MPT_OFF_OUT_CTRL, 32'h0);
		$display("mid-run reset done");
		conclude();
	end
endmodule
`default_nettype wire
